// file: hw/jtp_consts.vh
// constants of the test access port with port reclaim
`ifndef JTP_CONSTS_VH
`define JTP_CONSTS_VH

`define JTP_IR_LEN 5
`define JTP_IR_EXTEST 5'h00
`define JTP_IR_IDCODE 5'h01
`define JTP_IR_SAMPLE 5'h02
`define JTP_IR_HIGHZ 5'h05
`define JTP_IR_BYPASS 5'h1F
// value loaded into the instruction register on capture
`define JTP_IR_CAPTURE 5'h01
`define JTP_ID_LEN 32
// number of pins covered by the boundary register
`define JTP_NPINS 4
// boundary register field positions: pin inputs, pin data, pin enables
`define JTP_BSR_IN_LSB 0
`define JTP_BSR_OUT_LSB 4
`define JTP_BSR_OE_LSB 8
`define JTP_BSR_LEN 12
// buffer in the serial output path
`define JTP_BUF_W 1

`endif

// file: hw/jtp_buf2.v
// two-entry buffer with valid and ready on both sides
module jtp_buf2 #(
  parameter W = 1
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [W-1:0] i_in_data,
  output reg o_out_valid,
  input wire i_out_ready,
  output reg [W-1:0] o_out_data
);
  reg [W-1:0] spare_q;
  reg spare_vld_q;

  // ready while the spare slot is free, so a stalled reader never loses a word
  assign o_in_ready = ~spare_vld_q;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_out_valid <= 1'b0;
      o_out_data <= {W{1'b0}};
      spare_q <= {W{1'b0}};
      spare_vld_q <= 1'b0;
    end else begin
      if (!o_out_valid || i_out_ready) begin
        if (spare_vld_q) begin
          o_out_data <= spare_q;
          o_out_valid <= 1'b1;
          spare_vld_q <= i_in_valid;
          spare_q <= i_in_data;
        end else begin
          o_out_data <= i_in_data;
          o_out_valid <= i_in_valid;
        end
      end else if (i_in_valid && !spare_vld_q) begin
        spare_q <= i_in_data;
        spare_vld_q <= 1'b1;
      end
    end
  end
endmodule // jtp_buf2

// file: hw/jtp_tap.v
// test access port with boundary scan and test pin reclaim
//
// Operation
// R1: sample instruction captures pins into boundary register
// R2: sample update loads boundary parallel outputs
// R3: extest drives boundary parallel outputs onto pins
// R4: bypass instruction places one-bit stage TDI-TDO
// R5: controller may shift all ones for bypass
// R6: idcode shifts identification value out TDO
// R7: high-z instruction floats all system outputs
// R8: power-up reset resets test logic, no TRST
// R9: user-io pins lose test function unless enabled
// R10: port enable low restores user io function
// R11: system holds port enable low at power-up
// R12: unconfigured device keeps pins as test port
// R13: weak pull-ups enabled on test port pins
// R14: pin logic cells stay usable as buried logic
// R15: system ties port enable low if unused
// R16: TDI sampled on rising TCK
// R17: TDO changes on falling TCK, else floats
// R18: high-z instruction selects bypass stage
// R19: controller keeps TMS high in user mode
// R20: controller follows sixteen-state sequence on TMS
// R21: undefined instruction codes select bypass stage
`include "jtp_consts.vh"

module jtp_tap #(
  parameter [31:0] IDCODE_VALUE = 32'h00000001 // arbitrary value
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_tck,
  input wire i_tms,
  input wire i_tdi,
  input wire i_port_en,
  input wire i_user_io_cfg,
  input wire [`JTP_NPINS-1:0] i_pin_in,
  input wire [`JTP_NPINS-1:0] i_sys_out,
  input wire [`JTP_NPINS-1:0] i_sys_oe,
  output reg o_tdo,
  output reg o_tdo_oe,
  output reg o_test_mode,
  output reg o_pullup_en,
  output reg o_buried_en,
  output reg [`JTP_NPINS-1:0] o_pin_out,
  output reg [`JTP_NPINS-1:0] o_pin_oe
);
  localparam [3:0] ST_RESET = 4'h0;
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_SEL_DR = 4'h2;
  localparam [3:0] ST_CAP_DR = 4'h3;
  localparam [3:0] ST_SHIFT_DR = 4'h4;
  localparam [3:0] ST_EXIT1_DR = 4'h5;
  localparam [3:0] ST_PAUSE_DR = 4'h6;
  localparam [3:0] ST_EXIT2_DR = 4'h7;
  localparam [3:0] ST_UPD_DR = 4'h8;
  localparam [3:0] ST_SEL_IR = 4'h9;
  localparam [3:0] ST_CAP_IR = 4'hA;
  localparam [3:0] ST_SHIFT_IR = 4'hB;
  localparam [3:0] ST_EXIT1_IR = 4'hC;
  localparam [3:0] ST_PAUSE_IR = 4'hD;
  localparam [3:0] ST_EXIT2_IR = 4'hE;
  localparam [3:0] ST_UPD_IR = 4'hF;

  // two-flop synchronisers for every pin input
  reg [`JTP_NPINS+4:0] sync1_q;
  reg [`JTP_NPINS+4:0] sync2_q;
  reg tck_prev_q;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= {(`JTP_NPINS+5){1'b0}};
      sync2_q <= {(`JTP_NPINS+5){1'b0}};
      tck_prev_q <= 1'b0;
    end else begin
      sync1_q <= {i_pin_in, i_user_io_cfg, i_port_en, i_tdi, i_tms, i_tck};
      sync2_q <= sync1_q;
      tck_prev_q <= sync2_q[0];
    end
  end

  wire tck_s = sync2_q[0];
  wire tms_s = sync2_q[1];
  wire tdi_s = sync2_q[2];
  wire port_en_s = sync2_q[3];
  wire user_cfg_s = sync2_q[4];
  wire [`JTP_NPINS-1:0] pin_in_s = sync2_q[`JTP_NPINS+4:5];
  wire tck_rise = tck_s & ~tck_prev_q;
  wire tck_fall = ~tck_s & tck_prev_q;

  // pins act as the test port when unconfigured or reclaimed
  wire test_mode = ~user_cfg_s | port_en_s; // [R9] [R10] [R12]

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [`JTP_IR_LEN-1:0] ir_shift_q;
  reg [`JTP_IR_LEN-1:0] ir_q;
  reg [`JTP_BSR_LEN-1:0] bsr_shift_q;
  reg [`JTP_BSR_LEN-1:0] bsr_upd_q;
  reg [`JTP_ID_LEN-1:0] id_shift_q;
  reg bypass_q;
  reg rise_d1_q;

  always @* begin
    state_d = state_q;
    case (state_q) // [R20]
      ST_RESET: state_d = tms_s ? ST_RESET : ST_IDLE;
      ST_IDLE: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_d = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_d = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_d = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: state_d = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_d = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_d = tms_s ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_d = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_d = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_d = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: state_d = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_d = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
      default: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
    endcase
  end

  // data register selection; every other code falls to bypass
  wire sel_bsr = (ir_q == `JTP_IR_SAMPLE) | (ir_q == `JTP_IR_EXTEST); // [R1] [R3]
  wire sel_id = (ir_q == `JTP_IR_IDCODE); // [R6]
  wire sel_byp = ~sel_bsr & ~sel_id; // [R4] [R18] [R21]

  // output buffer toward the serial output stage
  wire buf_in_ready;
  wire buf_out_valid;
  wire [`JTP_BUF_W-1:0] buf_out_data;
  wire shifting = (state_q == ST_SHIFT_DR) | (state_q == ST_SHIFT_IR);
  reg serial_bit;
  always @* begin
    serial_bit = bypass_q;
    if (state_q == ST_SHIFT_IR) begin
      serial_bit = ir_shift_q[0];
    end else if (sel_bsr) begin
      serial_bit = bsr_shift_q[0];
    end else if (sel_id) begin
      serial_bit = id_shift_q[0];
    end
  end
  wire push = rise_d1_q & shifting & test_mode;

  jtp_buf2 #(
    .W(`JTP_BUF_W)
  ) u_buf (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in_valid(push),
    .o_in_ready(buf_in_ready),
    .i_in_data(serial_bit),
    .o_out_valid(buf_out_valid),
    .i_out_ready(tck_fall),
    .o_out_data(buf_out_data)
  );

  // a rising edge is only taken while the buffer can accept the next bit
  wire step = tck_rise & buf_in_ready & test_mode;

  // power-up reset resets the test logic, no TRST; user-io mode also holds it in reset
  always @(posedge i_clk or posedge i_rst) begin // [R8]
    if (i_rst) begin
      state_q <= ST_RESET;
      ir_shift_q <= `JTP_IR_IDCODE;
      ir_q <= `JTP_IR_IDCODE;
      bsr_shift_q <= {`JTP_BSR_LEN{1'b0}};
      bsr_upd_q <= {`JTP_BSR_LEN{1'b0}};
      id_shift_q <= {`JTP_ID_LEN{1'b0}};
      bypass_q <= 1'b0;
      rise_d1_q <= 1'b0;
    end else begin
      rise_d1_q <= step;
      if (!test_mode) begin
        // pins belong to user io: test logic held in reset
        state_q <= ST_RESET; // [R9]
        ir_q <= `JTP_IR_IDCODE;
      end else if (step) begin // [R16]
        state_q <= state_d;
        case (state_q)
          ST_RESET: begin
            ir_q <= `JTP_IR_IDCODE;
          end
          ST_CAP_IR: begin
            ir_shift_q <= `JTP_IR_CAPTURE;
          end
          ST_SHIFT_IR: begin
            ir_shift_q <= {tdi_s, ir_shift_q[`JTP_IR_LEN-1:1]}; // [R5]
          end
          ST_UPD_IR: begin
            ir_q <= ir_shift_q;
          end
          ST_CAP_DR: begin
            if (sel_bsr) begin
              bsr_shift_q <= {i_sys_oe, i_sys_out, pin_in_s}; // [R1]
            end
            if (sel_id) begin
              id_shift_q <= IDCODE_VALUE; // [R6]
            end
            bypass_q <= 1'b0;
          end
          ST_SHIFT_DR: begin
            if (sel_bsr) begin
              bsr_shift_q <= {tdi_s, bsr_shift_q[`JTP_BSR_LEN-1:1]};
            end else if (sel_id) begin
              id_shift_q <= {tdi_s, id_shift_q[`JTP_ID_LEN-1:1]};
            end else begin
              bypass_q <= tdi_s; // [R4] [R18]
            end
          end
          ST_UPD_DR: begin
            if (sel_bsr) begin
              bsr_upd_q <= bsr_shift_q; // [R2]
            end
          end
          default: begin
            bypass_q <= bypass_q;
          end
        endcase
      end
    end
  end

  // serial output changes on falling edges in test mode, floats outside shifting and at once in user mode
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else if (!test_mode) begin
      o_tdo_oe <= 1'b0;
    end else if (tck_fall) begin // [R17]
      o_tdo_oe <= shifting & buf_out_valid;
      if (buf_out_valid) begin
        o_tdo <= buf_out_data[0];
      end
    end
  end

  // system pin drive: core, boundary outputs, or released
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin_out <= {`JTP_NPINS{1'b0}};
      o_pin_oe <= {`JTP_NPINS{1'b0}};
      o_test_mode <= 1'b0;
      o_pullup_en <= 1'b0;
      o_buried_en <= 1'b0;
    end else begin
      o_test_mode <= test_mode;
      o_pullup_en <= test_mode; // [R13]
      o_buried_en <= 1'b1; // [R14]
      if (ir_q == `JTP_IR_HIGHZ) begin
        o_pin_out <= i_sys_out;
        o_pin_oe <= {`JTP_NPINS{1'b0}}; // [R7]
      end else if (ir_q == `JTP_IR_EXTEST) begin
        o_pin_out <= bsr_upd_q[`JTP_BSR_OUT_LSB+`JTP_NPINS-1:`JTP_BSR_OUT_LSB]; // [R3]
        o_pin_oe <= bsr_upd_q[`JTP_BSR_OE_LSB+`JTP_NPINS-1:`JTP_BSR_OE_LSB];
      end else begin
        o_pin_out <= i_sys_out; // [R1]
        o_pin_oe <= i_sys_oe;
      end
    end
  end
endmodule // jtp_tap

// file: verif/jtp_tap_sva.sv
// port assertions of the test access port
`include "jtp_consts.vh"
module jtp_tap_sva (
  input wire i_clk,
  input wire i_rst,
  input wire i_tck,
  input wire i_port_en,
  input wire i_user_io_cfg,
  input wire [`JTP_NPINS-1:0] i_sys_out,
  input wire [`JTP_NPINS-1:0] i_sys_oe,
  input wire o_tdo,
  input wire o_tdo_oe,
  input wire o_test_mode,
  input wire o_pullup_en,
  input wire o_buried_en,
  input wire [`JTP_NPINS-1:0] o_pin_out,
  input wire [`JTP_NPINS-1:0] o_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_test_req;
    (!i_user_io_cfg || i_port_en) [*4];
  endsequence
  sequence s_user_req;
    (i_user_io_cfg && !i_port_en) [*4];
  endsequence
  a_test_port_on: assert property (s_test_req |-> o_test_mode)
    else $error("test port not active");
  a_user_io_back: assert property (s_user_req |-> !o_test_mode)
    else $error("test port kept active");
  a_pullup_follow: assert property (o_pullup_en == o_test_mode)
    else $error("pull-up differs from test role");
  a_buried_kept: assert property (!$past(i_rst) |-> o_buried_en)
    else $error("buried logic disabled");
  a_reset_quiet: assert property ($fell(i_rst) |-> !o_tdo_oe && o_pin_oe == 4'h0)
    else $error("outputs active out of reset");
  a_tdo_on_fall: assert property (o_test_mode && $past(o_test_mode)
    && ($changed(o_tdo_oe) || o_tdo_oe && $changed(o_tdo)) |-> !$past(i_tck, 2))
    else $error("serial out moved off a falling link edge");
  a_refused_float: assert property ((!o_test_mode) [*4] |-> !o_tdo_oe)
    else $error("serial out driven in user mode");
  a_pins_follow: assert property ((!o_test_mode) [*6] |->
    o_pin_out == $past(i_sys_out) && o_pin_oe == $past(i_sys_oe))
    else $error("pins do not follow core");
endmodule // jtp_tap_sva

bind jtp_tap jtp_tap_sva jtp_tap_sva_i (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_tck(i_tck),
  .i_port_en(i_port_en),
  .i_user_io_cfg(i_user_io_cfg),
  .i_sys_out(i_sys_out),
  .i_sys_oe(i_sys_oe),
  .o_tdo(o_tdo),
  .o_tdo_oe(o_tdo_oe),
  .o_test_mode(o_test_mode),
  .o_pullup_en(o_pullup_en),
  .o_buried_en(o_buried_en),
  .o_pin_out(o_pin_out),
  .o_pin_oe(o_pin_oe)
);

// file: verif/jtp_ctl_model.sv
// behavioural external test controller on the link
module jtp_ctl_model (
  input wire logic i_clk,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo,
  input wire logic i_tdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_tck = 1'h0;
    o_tms = 1'h1;
    o_tdi = 1'h1;
  end
  // set lines while link clock is low, read serial out late in the high phase
  task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe);
    o_tms = tms;
    o_tdi = tdi;
    repeat (4) @(posedge i_clk);
    #1 o_tck = 1'h1;
    repeat (4) @(posedge i_clk);
    // a released serial out reads as its weak pull-up level
    #1 tdo = i_tdo_oe ? i_tdo : 1'h1;
    oe = i_tdo_oe;
    o_tck = 1'h0;
  endtask
  // idle, capture, shift n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [39:0] din,
                      output logic [39:0] dout, output logic ok);
    logic t;
    logic e;
    dout = '0;
    step(1'h0, 1'h1, t, e);
    step(1'h1, 1'h1, t, e);
    if (ir) step(1'h1, 1'h1, t, e);
    step(1'h0, 1'h1, t, e);
    step(1'h0, 1'h1, t, e);
    ok = !e;
    for (int k = 0; k < n; k++) begin
      step(k == n - 1, din[k], t, e);
      dout[k] = t;
      ok &= e;
    end
    step(1'h1, 1'h1, t, e);
    ok &= !e;
    step(1'h0, 1'h1, t, e);
    o_tms = 1'h1;
    // let an edge pass so a following scan never moves the mode line in the same step
    @(posedge i_clk);
    #1;
  endtask
endmodule // jtp_ctl_model

// file: verif/jtp_tap_test.sv
// self-checking bench of the test access port with port reclaim
`include "jtp_consts.vh"
module jtp_tap_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ID = 32'h5A3C96E1; // arbitrary identity value
  logic i_clk = 1'h0, i_rst = 1'h1, i_port_en = 1'h0, i_user_io_cfg = 1'h0;
  logic [3:0] i_pin_in = 4'h9, i_sys_out = 4'h6, i_sys_oe = 4'hC;
  wire i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe, o_test_mode, o_pullup_en, o_buried_en;
  wire [3:0] o_pin_out, o_pin_oe;
  int n_mismatch = 0, checks_done = 0;
  logic [39:0] r;
  logic ok;
  always #20 i_clk = ~i_clk;
  jtp_tap #(.IDCODE_VALUE(ID)) jtp_tap_i (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_tck(i_tck),
    .i_tms(i_tms),
    .i_tdi(i_tdi),
    .i_port_en(i_port_en),
    .i_user_io_cfg(i_user_io_cfg),
    .i_pin_in(i_pin_in),
    .i_sys_out(i_sys_out),
    .i_sys_oe(i_sys_oe),
    .o_tdo(o_tdo),
    .o_tdo_oe(o_tdo_oe),
    .o_test_mode(o_test_mode),
    .o_pullup_en(o_pullup_en),
    .o_buried_en(o_buried_en),
    .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe)
  );
  jtp_ctl_model jtp_ctl_model_i (.i_clk, .o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi),
    .i_tdo(o_tdo), .i_tdo_oe(o_tdo_oe));
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic do_reset;
    i_rst = 1'h1;
    wt(20);
    i_rst = 1'h0;
    wt(4);
  endtask
  task automatic load_ir(input logic [4:0] code);
    jtp_ctl_model_i.scan(1'h1, 5, {35'h0, code}, r, ok);
    chk(r[4:0], `JTP_IR_CAPTURE);
    chk(ok, 1'h1);
  endtask
  task automatic t_idcode;
    jtp_ctl_model_i.scan(1'h0, 32, 40'h0, r, ok);
    chk(ok, 1'h1);
    chk(r[31:0], ID);
    chk({o_test_mode, o_pullup_en, o_buried_en}, 3'h7);
  endtask
  task automatic t_bypass;
    logic [4:0] codes [4] = '{5'h1F, `JTP_IR_HIGHZ, 5'h03, 5'h09};
    foreach (codes[i]) begin
      load_ir(codes[i]);
      chk(o_pin_oe, codes[i] == `JTP_IR_HIGHZ ? 4'h0 : i_sys_oe);
      jtp_ctl_model_i.scan(1'h0, 8, 40'hB5, r, ok);
      chk(r[7:0], 8'h6A);
    end
  endtask
  task automatic t_boundary;
    load_ir(`JTP_IR_SAMPLE);
    jtp_ctl_model_i.scan(1'h0, 12, 40'hA50, r, ok);
    chk(r[3:0], i_pin_in);
    chk(r[11:4], {i_sys_oe, i_sys_out});
    chk(ok, 1'h1);
    chk({o_pin_oe, o_pin_out}, {i_sys_oe, i_sys_out});
    load_ir(`JTP_IR_EXTEST);
    chk({o_pin_oe, o_pin_out}, 8'hA5);
  endtask
  task automatic t_reclaim;
    i_user_io_cfg = 1'h1;
    wt(8);
    chk(o_test_mode, 1'h0);
    jtp_ctl_model_i.scan(1'h1, 5, 40'h0, r, ok);
    chk(ok, 1'h0);
    i_port_en = 1'h1;
    wt(8);
    t_idcode();
    i_port_en = 1'h0;
    wt(8);
    chk({o_test_mode, o_pullup_en, o_pin_oe}, {2'h0, i_sys_oe});
    i_user_io_cfg = 1'h0;
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    do_reset();
    t_idcode();
    t_bypass();
    do_reset();
    t_idcode();
    t_boundary();
    t_reclaim();
    report_and_stop();
  end
  initial begin
    #1000000;
    n_mismatch++;
    report_and_stop();
  end
endmodule // jtp_tap_test
